// >>> hw/dms_steer.sv
// Data memory access steering: registers, move sequencer, address resolver
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module dms_steer (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire dms_pkg::dms_wb_req_s wb_req_in,
	output dms_pkg::dms_wb_rsp_s wb_rsp_out,
	input wire dms_pkg::dms_core_acc_s core_acc_in,
	output dms_pkg::dms_region_s region_out,
	input wire logic [7:0] p0_in,
	output dms_pkg::dms_ext_bus_s ext_bus_out,
	output logic ale_out
);
	import dms_pkg::*;

	// Register map by word index (byte address is four times it):
	//   82/83  Low and high byte of whichever pointer the select bit picks
	//   8e     Memory control: bit 1 external RAM select, bit 0 latch strobe off
	//   8f     Clock control: bit 0 double speed
	//   a0     Port 2 latch, shown on port 2 outside pointer bus cycles
	//   a2     Pointer select: bit 0 select, bit 3 user flag
	//   10     Move command: start, write, use pointer, code read
	//   11     Address byte for register-indirect moves
	//   12     Move data: write data in, read result out
	//   13     Status: bit 0 busy, bit 1 last move went off chip
	//   14     Any write inverts the pointer select
	// Writes to 10 and 12 are dropped while a move runs, so software polls
	// the busy bit before it starts the next move.

	typedef enum logic [2:0] {
		DMS_ST_IDLE,
		DMS_ST_INT_ACC,
		DMS_ST_INT_WAIT,
		DMS_ST_EXT_ADDR,
		DMS_ST_EXT_STROBE,
		DMS_ST_EXT_END
	} dms_state_e;

	typedef struct packed {
		dms_wb_rsp_s rsp;
		logic [15:0] ptr_zero;
		logic [15:0] ptr_one;
		logic ptr_sel;
		logic user_flag;
		logic ext_ram_sel;
		logic addr_latch_off;
		logic double_speed;
		logic [7:0] port2_latch;
		logic [7:0] move_addr;
		logic [7:0] move_data;
		logic cmd_write;
		logic cmd_pointer;
		logic last_ext;
		dms_state_e fsm;
		logic [2:0] cnt;
		logic [15:0] addr;
		logic ale_req;
		dms_ext_bus_s bus;
		dms_region_s region;
	} dms_steer_state_s;

	dms_steer_state_s st_reg;
	dms_steer_state_s st_next;
	logic [7:0] eram_rdata;
	logic eram_en;
	logic eram_we;
	logic wr_hit;
	logic rd_take;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic [15:0] sel_ptr;
	logic [15:0] new_addr;
	logic busy;
	logic ext_busy;

	////////////////////////////////////////////////////////////////////////////
	// Sub-blocks

	// Expanded RAM, used when a move stays on chip
	dms_exp_ram u_eram (
		.core_clk_in(core_clk_in),
		.en_in(eram_en),
		.we_in(eram_we),
		.addr_in(st_reg.addr[DMS_EXP_RAM_AW-1:0]),
		.wdata_in(st_reg.move_data),
		.rdata_out(eram_rdata)
	);

	// Latch strobe generator; also pulses on request from the sequencer
	dms_ale_gen u_ale (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.addr_latch_off_in(st_reg.addr_latch_off || ext_busy),
		.double_speed_in(st_reg.double_speed),
		.move_req_in(st_reg.ale_req),
		.ale_out(ale_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode helpers

	// Word index selects the register; byte lane zero qualifies writes only
	// The acknowledge follows one cycle after the request; a write lands
	// on the edge where it is high, so the master sees it take effect then.
	assign idx = wb_req_in.adr[9:2];
	assign wbyte = wb_req_in.dat[7:0];
	assign wr_hit = wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && st_reg.rsp.ack
		&& wb_req_in.sel[0];
	assign rd_take = wb_req_in.cyc && wb_req_in.stb && !st_reg.rsp.ack;
	assign busy = (st_reg.fsm != DMS_ST_IDLE);
	assign sel_ptr = st_reg.ptr_sel ? st_reg.ptr_one : st_reg.ptr_zero;
	// Expanded RAM port driven only in internal access state
	assign eram_en = (st_reg.fsm == DMS_ST_INT_ACC);
	assign eram_we = (st_reg.fsm == DMS_ST_INT_ACC) && st_reg.cmd_write;
	// External cycle in flight; the free-running latch strobe is held off
	// so that data on port 0 is never latched as an address
	// free strobe paused during bus cycle
	assign ext_busy = (st_reg.fsm == DMS_ST_EXT_ADDR) || (st_reg.fsm == DMS_ST_EXT_STROBE)
		|| (st_reg.fsm == DMS_ST_EXT_END);

	// Read mux; reserved bits read as zero
	always_comb begin
		rbyte = 8'h00;
		case (idx)
			DMS_IDX_PTR_LOW: rbyte = sel_ptr[7:0];
			DMS_IDX_PTR_HIGH: rbyte = sel_ptr[15:8];
			DMS_IDX_AUX_MEM: begin
				rbyte[DMS_BIT_EXT_RAM_SEL] = st_reg.ext_ram_sel;
				rbyte[DMS_BIT_ADDR_LATCH_OFF] = st_reg.addr_latch_off;
			end
			DMS_IDX_CLK_CTRL: rbyte[DMS_BIT_DOUBLE_SPEED] = st_reg.double_speed;
			DMS_IDX_PORT2: rbyte = st_reg.port2_latch;
			DMS_IDX_PTR_SEL: begin
				rbyte[DMS_BIT_PTR_SEL] = st_reg.ptr_sel;
				rbyte[DMS_BIT_USER_FLAG] = st_reg.user_flag;
			end
			DMS_IDX_MOVE_ADDR: rbyte = st_reg.move_addr;
			DMS_IDX_MOVE_DATA: rbyte = st_reg.move_data;
			DMS_IDX_STATUS: rbyte = {6'h00, st_reg.last_ext, busy};
			default: rbyte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		st_next = st_reg;
		new_addr = 16'h0000;
		st_next.ale_req = 1'b0;

		// Single-cycle acknowledge, dropped the cycle after
		st_next.rsp.ack = rd_take;
		if (rd_take) begin
			st_next.rsp.dat = {24'h000000, rbyte};
		end

		// Address resolver for the core's internal accesses; one cycle of
		// latency, so the region stands beside the address the core sent.
		// Stack accesses count as indirect: the stack lives in internal RAM.
		st_next.region.valid = core_acc_in.valid;
		st_next.region.addr = core_acc_in.addr;
		if (core_acc_in.addr <= DMS_LOWER_TOP) begin
			st_next.region.region = DMS_REG_LOWER;
		end else if (core_acc_in.indirect || core_acc_in.stack) begin
			st_next.region.region = DMS_REG_UPPER;
		end else begin
			st_next.region.region = DMS_REG_SPECIAL;
		end

		// Register writes take effect at the acknowledge edge
		if (wr_hit) begin
			case (idx)
				DMS_IDX_PTR_LOW: begin
					// writes land on the active pointer
					if (st_reg.ptr_sel) begin
						st_next.ptr_one[7:0] = wbyte;
					end else begin
						st_next.ptr_zero[7:0] = wbyte;
					end
				end
				DMS_IDX_PTR_HIGH: begin
					if (st_reg.ptr_sel) begin
						st_next.ptr_one[15:8] = wbyte;
					end else begin
						st_next.ptr_zero[15:8] = wbyte;
					end
				end
				DMS_IDX_AUX_MEM: begin
					st_next.ext_ram_sel = wbyte[DMS_BIT_EXT_RAM_SEL];
					st_next.addr_latch_off = wbyte[DMS_BIT_ADDR_LATCH_OFF];
				end
				DMS_IDX_CLK_CTRL: st_next.double_speed = wbyte[DMS_BIT_DOUBLE_SPEED];
				DMS_IDX_PORT2: st_next.port2_latch = wbyte;
				DMS_IDX_PTR_SEL: begin
					st_next.ptr_sel = wbyte[DMS_BIT_PTR_SEL];
					st_next.user_flag = wbyte[DMS_BIT_USER_FLAG];
				end
				DMS_IDX_SEL_TOGGLE: st_next.ptr_sel = !st_reg.ptr_sel;
				DMS_IDX_MOVE_ADDR: st_next.move_addr = wbyte;
				DMS_IDX_MOVE_DATA: begin
					if (!busy) begin
						st_next.move_data = wbyte;
					end
				end
				DMS_IDX_MOVE_CMD: begin
					if (!busy && wbyte[DMS_BIT_CMD_CODE_READ]) begin
						st_next.ale_req = 1'b1;
					end
					if (!busy && wbyte[DMS_BIT_CMD_START]) begin
						st_next.cmd_write = wbyte[DMS_BIT_CMD_WRITE];
						st_next.cmd_pointer = wbyte[DMS_BIT_CMD_POINTER];
						new_addr = wbyte[DMS_BIT_CMD_POINTER] ? sel_ptr
							: {8'h00, st_reg.move_addr};
						st_next.addr = new_addr;
						// expanded RAM at bottom of space
						if (!st_reg.ext_ram_sel && new_addr <= DMS_EXP_RAM_TOP) begin
							st_next.fsm = DMS_ST_INT_ACC;
							st_next.last_ext = 1'b0;
						end else begin
							st_next.fsm = DMS_ST_EXT_ADDR;
							st_next.cnt = 3'h0;
							st_next.last_ext = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Move sequencer. An external move runs, counted from the command edge:
		//   two address cycles with port 0 driven, latch strobe in the second,
		//   three strobe cycles with read or write low,
		//   one closing cycle that takes read data and floats port 0.
		// An internal move spends one cycle at the RAM port and one taking data.
		case (st_reg.fsm)
			DMS_ST_IDLE: begin
			end
			DMS_ST_INT_ACC: st_next.fsm = DMS_ST_INT_WAIT;
			DMS_ST_INT_WAIT: begin
				if (!st_reg.cmd_write) begin
					st_next.move_data = eram_rdata;
				end
				st_next.fsm = DMS_ST_IDLE;
			end
			DMS_ST_EXT_ADDR: begin
				st_next.bus.p0_out = st_reg.addr[7:0];
				st_next.bus.p0_oe = 1'b1;
				st_next.bus.p2_out = st_reg.cmd_pointer ? st_reg.addr[15:8]
					: st_reg.port2_latch;
				st_next.ale_req = (st_reg.cnt == 3'h0);
				st_next.cnt = st_reg.cnt + 3'h1;
				if (st_reg.cnt == DMS_ADDR_CYCLES - 3'h1) begin
					st_next.cnt = 3'h0;
					st_next.fsm = DMS_ST_EXT_STROBE;
				end
			end
			DMS_ST_EXT_STROBE: begin
				st_next.bus.p0_out = st_reg.move_data;
				st_next.bus.p0_oe = st_reg.cmd_write;
				st_next.bus.rd_n = st_reg.cmd_write;
				st_next.bus.wr_n = !st_reg.cmd_write;
				st_next.cnt = st_reg.cnt + 3'h1;
				if (st_reg.cnt == DMS_STROBE_CYCLES - 3'h1) begin
					st_next.cnt = 3'h0;
					st_next.fsm = DMS_ST_EXT_END;
				end
			end
			DMS_ST_EXT_END: begin
				// Read data sampled as the strobe ends
				if (!st_reg.cmd_write) begin
					st_next.move_data = p0_in;
				end
				st_next.bus.rd_n = 1'b1;
				st_next.bus.wr_n = 1'b1;
				st_next.bus.p0_oe = 1'b0;
				st_next.bus.p2_out = st_reg.port2_latch;
				st_next.fsm = DMS_ST_IDLE;
			end
			default: st_next.fsm = DMS_ST_IDLE;
		endcase

		// Port 2 follows its latch outside external cycles
		if (st_reg.fsm == DMS_ST_IDLE || st_reg.fsm == DMS_ST_INT_ACC
			|| st_reg.fsm == DMS_ST_INT_WAIT) begin
			st_next.bus.p2_out = st_next.port2_latch;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	// Every flop resets to a constant; port 2 and the strobes idle high
	// control bits reset to zero
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
			st_reg.ptr_zero <= DMS_PTR_RESET;
			st_reg.ptr_one <= DMS_PTR_RESET;
			st_reg.port2_latch <= DMS_PORT2_RESET;
			st_reg.fsm <= DMS_ST_IDLE;
			st_reg.bus.p2_out <= DMS_PORT2_RESET;
			st_reg.bus.rd_n <= 1'b1;
			st_reg.bus.wr_n <= 1'b1;
			st_reg.region.region <= DMS_REG_LOWER;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	// No logic between the flops and the pins, so no glitches reach them

	assign wb_rsp_out = st_reg.rsp;
	assign region_out = st_reg.region;
	assign ext_bus_out = st_reg.bus;
endmodule
`default_nettype wire

// >>> hw/dms_pkg.sv
// Package for the data memory access steering block: map, fields, types
package dms_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] DMS_IDX_PTR_LOW = 8'h82;
	localparam logic [7:0] DMS_IDX_PTR_HIGH = 8'h83;
	localparam logic [7:0] DMS_IDX_AUX_MEM = 8'h8e;
	localparam logic [7:0] DMS_IDX_CLK_CTRL = 8'h8f;
	localparam logic [7:0] DMS_IDX_PORT2 = 8'ha0;
	localparam logic [7:0] DMS_IDX_PTR_SEL = 8'ha2;
	localparam logic [7:0] DMS_IDX_MOVE_CMD = 8'h10;
	localparam logic [7:0] DMS_IDX_MOVE_ADDR = 8'h11;
	localparam logic [7:0] DMS_IDX_MOVE_DATA = 8'h12;
	localparam logic [7:0] DMS_IDX_STATUS = 8'h13;
	localparam logic [7:0] DMS_IDX_SEL_TOGGLE = 8'h14;

	// Field positions
	localparam int DMS_BIT_PTR_SEL = 0;
	localparam int DMS_BIT_USER_FLAG = 3;
	localparam int DMS_BIT_ADDR_LATCH_OFF = 0;
	localparam int DMS_BIT_EXT_RAM_SEL = 1;
	localparam int DMS_BIT_DOUBLE_SPEED = 0;
	localparam int DMS_BIT_CMD_START = 0;
	localparam int DMS_BIT_CMD_WRITE = 1;
	localparam int DMS_BIT_CMD_POINTER = 2;
	localparam int DMS_BIT_CMD_CODE_READ = 3;

	// Reset values
	localparam logic [15:0] DMS_PTR_RESET = 16'h0000;
	localparam logic [7:0] DMS_PORT2_RESET = 8'hff;

	// Expanded RAM geometry
	localparam int DMS_EXP_RAM_BYTES = 768;
	localparam int DMS_EXP_RAM_AW = 10;
	localparam logic [15:0] DMS_EXP_RAM_TOP = 16'h02ff;
	localparam logic [7:0] DMS_LOWER_TOP = 8'h7f;

	// Oscillator periods between strobes and bus phase lengths in cycles
	localparam logic [2:0] DMS_ALE_STD_PERIOD = 3'h6;
	localparam logic [2:0] DMS_ALE_FAST_PERIOD = 3'h3;
	localparam logic [2:0] DMS_ADDR_CYCLES = 3'h2;
	localparam logic [2:0] DMS_STROBE_CYCLES = 3'h3;

	typedef enum logic [1:0] {
		DMS_REG_LOWER,
		DMS_REG_UPPER,
		DMS_REG_SPECIAL
	} dms_region_e;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [9:0] adr;
		logic [31:0] dat;
	} dms_wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} dms_wb_rsp_s;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic indirect;
		logic stack;
	} dms_core_acc_s;

	typedef struct packed {
		logic valid;
		dms_region_e region;
		logic [7:0] addr;
	} dms_region_s;

	typedef struct packed {
		logic [7:0] p0_out;
		logic p0_oe;
		logic [7:0] p2_out;
		logic rd_n;
		logic wr_n;
	} dms_ext_bus_s;

endpackage

// >>> hw/dms_expanded_ram.sv
// Expanded RAM array with registered read data
`timescale 1ns/100ps
`default_nettype none
module dms_exp_ram (
	input wire logic core_clk_in,
	input wire logic en_in,
	input wire logic we_in,
	input wire logic [dms_pkg::DMS_EXP_RAM_AW-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	import dms_pkg::*;

	logic [7:0] mem_reg [0:DMS_EXP_RAM_BYTES-1];

	// Synchronous write, registered read
	always_ff @(posedge core_clk_in) begin
		if (en_in) begin
			if (we_in) begin
				mem_reg[addr_in] <= wdata_in;
			end
			rdata_out <= mem_reg[addr_in];
		end
	end
endmodule
`default_nettype wire

// >>> hw/dms_ale_gen.sv
// Address latch strobe generator
`timescale 1ns/100ps
`default_nettype none
module dms_ale_gen (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic addr_latch_off_in,
	input wire logic double_speed_in,
	input wire logic move_req_in,
	output logic ale_out
);
	import dms_pkg::*;

	typedef struct packed {
		logic [2:0] cnt;
		logic ale;
	} dms_ale_state_s;

	dms_ale_state_s st_reg;
	dms_ale_state_s st_next;
	logic [2:0] period;

	// Count oscillator periods and emit the strobe
	always_comb begin
		st_next = st_reg;
		period = double_speed_in ? DMS_ALE_FAST_PERIOD : DMS_ALE_STD_PERIOD;
		if (st_reg.cnt >= period - 3'h1) begin
			st_next.cnt = 3'h0;
		end else begin
			st_next.cnt = st_reg.cnt + 3'h1;
		end
		st_next.ale = (!addr_latch_off_in && st_next.cnt == 3'h0) || move_req_in;
	end

	// State register
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ale_out = st_reg.ale;
endmodule
`default_nettype wire

// >>> test/dms_steer_assertions.sv
// Port checker for the steering block
`timescale 1ns/100ps
`default_nettype none
module dms_chk (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire dms_pkg::dms_wb_req_s wb_req_in,
	input wire dms_pkg::dms_wb_rsp_s wb_rsp_out,
	input wire dms_pkg::dms_core_acc_s core_acc_in,
	input wire dms_pkg::dms_region_s region_out,
	input wire logic [7:0] p0_in,
	input wire dms_pkg::dms_ext_bus_s ext_bus_out,
	input wire logic ale_out
);
	import dms_pkg::*;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////
	// Region resolver
	a_region_low: assert property (core_acc_in.valid && core_acc_in.addr <= DMS_LOWER_TOP
		|=> region_out.valid && region_out.region == DMS_REG_LOWER) else $error("low region");
	a_region_up: assert property (core_acc_in.valid && core_acc_in.addr > 8'h7f
		&& core_acc_in.indirect |=> region_out.region == DMS_REG_UPPER) else $error("upper");
	a_stack_up: assert property (core_acc_in.valid && core_acc_in.addr > 8'h7f
		&& core_acc_in.stack |=> region_out.region == DMS_REG_UPPER) else $error("stack");
	a_region_spec: assert property (core_acc_in.valid && core_acc_in.addr > 8'h7f
		&& !core_acc_in.indirect && !core_acc_in.stack
		|=> region_out.region == DMS_REG_SPECIAL && region_out.addr == $past(core_acc_in.addr))
		else $error("special");
	////////////////////////////////////////
	// External bus cycle shape
	a_read_len: assert property ($fell(ext_bus_out.rd_n)
		|-> !ext_bus_out.rd_n[*3] ##1 ext_bus_out.rd_n) else $error("read strobe");
	a_write_len: assert property ($fell(ext_bus_out.wr_n)
		|-> (!ext_bus_out.wr_n && ext_bus_out.p0_oe)[*3] ##1 ext_bus_out.wr_n)
		else $error("write strobe");
	a_read_float: assert property (!ext_bus_out.rd_n |-> !ext_bus_out.p0_oe)
		else $error("port driven in read");
	a_ale_ahead: assert property ($fell(ext_bus_out.rd_n) || $fell(ext_bus_out.wr_n)
		|-> $past(ale_out)) else $error("no latch strobe");
	// Main scenarios
	cover property ($fell(ext_bus_out.rd_n));
	cover property ($fell(ext_bus_out.wr_n));
	cover property (region_out.valid && region_out.region == DMS_REG_SPECIAL);
endmodule
bind dms_steer dms_chk i_chk (
	.core_clk_in(core_clk_in),
	.rst_in(rst_in),
	.wb_req_in(wb_req_in),
	.wb_rsp_out(wb_rsp_out),
	.core_acc_in(core_acc_in),
	.region_out(region_out),
	.p0_in(p0_in),
	.ext_bus_out(ext_bus_out),
	.ale_out(ale_out)
);
`default_nettype wire

// >>> test/dms_ext_mem.sv
// Model of the external data memory on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module dms_ext_mem (
	input wire logic core_clk_in,
	input wire logic ale_in,
	input wire dms_pkg::dms_ext_bus_s bus_in,
	input wire logic slow_in,
	output logic [7:0] p0_out
);
	import dms_pkg::*;
	logic [7:0] mem [0:65535];
	logic [15:0] adr_q = 16'h0000;
	logic [7:0] last_q = 8'h5a;
	logic [15:0] hit_q = 16'h0000;
	int n_lo = 0;
	always @(posedge core_clk_in) begin
		if (ale_in) begin
			adr_q <= {bus_in.p2_out, bus_in.p0_out};
		end
		if (!bus_in.wr_n) begin
			mem[adr_q] <= bus_in.p0_out;
		end
		// Address in use while a strobe is low; later free strobes relatch
		if (!bus_in.rd_n || !bus_in.wr_n) begin
			hit_q <= adr_q;
		end
		n_lo <= bus_in.rd_n ? 0 : n_lo + 1;
		last_q <= p0_out;
	end
	// Read data, late when slow; a released bus toggles every cycle
	assign p0_out = (!bus_in.rd_n && (!slow_in || n_lo >= 2)) ? mem[adr_q] : ~last_q;
endmodule
`default_nettype wire

// >>> test/test_dms_steer.sv
// Self-checking bench for the steering block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module test_dms_steer;
	import dms_pkg::*;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic slow = 1'b0;
	logic bus_seen = 1'b0;
	logic ale;
	logic [7:0] p0, d1, d2;
	logic [15:0] pa, pb;
	logic [31:0] rd_v;
	logic [63:0] nt;
	logic [9:0] na;
	logic [63:0] rq[$];
	logic [9:0] aq[$];
	int n_errors = 0;
	int cmp_count = 0;
	int n_ale = 0;
	int seed = 32'h5a894c38;
	dms_wb_req_s wbq = '0;
	dms_wb_rsp_s wbr;
	dms_core_acc_s acc = '0;
	dms_region_s reg_o;
	dms_ext_bus_s ext;
	dms_steer i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .wb_req_in(wbq),
		.wb_rsp_out(wbr), .core_acc_in(acc), .region_out(reg_o), .p0_in(p0),
		.ext_bus_out(ext), .ale_out(ale));
	dms_ext_mem i_mem (.core_clk_in(core_clk_in), .ale_in(ale), .bus_in(ext),
		.slow_in(slow), .p0_out(p0));
	////////////////////////////////////////
	// Clock
	initial begin
		forever #25 core_clk_in = ~core_clk_in;
	end
	// Output watcher: strobes, bus use, read and region notes
	always @(posedge core_clk_in) begin
		if (ale) n_ale <= n_ale + 1;
		if (!ext.rd_n || !ext.wr_n || ext.p0_oe) bus_seen <= 1'b1;
		if (wbr.ack && !wbq.we && rq.size() > 0) begin
			nt = rq.pop_front();
			`CHK(wbr.dat & nt[63:32], nt[31:0])
		end
		if (reg_o.valid && aq.size() > 0) begin
			na = aq.pop_front();
			`CHK({reg_o.region, reg_o.addr}, na)
		end
	end
	////////////////////////////////////////
	// Classic single bus cycle; reads note masked expectation
	task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d,
		input logic [7:0] m, input logic [7:0] e);
		if (!w) rq.push_back({24'h0, m, 24'h0, e});
		wbq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: {i, 2'b00}, dat: {24'h0, d}};
		do @(posedge core_clk_in); while (wbr.ack !== 1'b1);
		rd_v = wbr.dat;
		wbq.cyc <= 1'b0;
		wbq.stb <= 1'b0;
		@(posedge core_clk_in);
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		wb(1'b1, i, d, 8'h00, 8'h00);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m = 8'hff);
		wb(1'b0, i, 8'h00, m, e);
	endtask
	// Start a move and poll until not busy
	task automatic mv(input logic [7:0] c);
		wr(8'h10, c);
		do wb(1'b0, 8'h13, 8'h00, 8'h00, 8'h00); while (rd_v[0]);
	endtask
	task automatic setp(input logic [15:0] v);
		wr(8'h82, v[7:0]);
		wr(8'h83, v[15:8]);
	endtask
	task automatic cnt(input int e);
		int n0;
		n0 = n_ale;
		repeat (60) @(posedge core_clk_in);
		`CHK(n_ale - n0, e)
	endtask
	task automatic test_done();
		$display("Comparisons %0d, errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (20000) @(posedge core_clk_in);
		n_errors++;
		test_done();
	end
	// Main sequence
	initial begin
		int n0;
		repeat (8) @(posedge core_clk_in);
		rst_in <= 1'b0;
		@(posedge core_clk_in);
		pa = $random(seed);
		pb = $random(seed);
		d1 = $random(seed);
		d2 = ~d1;
		rd(8'h8e, 8'h00);
		rd(8'ha2, 8'h00);
		rd(8'h8f, 8'h00);
		rd(8'h3f, 8'h00);
		wr(8'ha2, 8'h08);
		rd(8'ha2, 8'h08);
		wr(8'h14, 8'h00);
		rd(8'ha2, 8'h09);
		setp(pb);
		wr(8'h14, 8'h00);
		setp(pa);
		rd(8'h83, pa[15:8]);
		wr(8'h14, 8'h00);
		rd(8'h82, pb[7:0]);
		setp(16'h0300);
		wr(8'h14, 8'h00);
		setp(16'h02ff);
		wr(8'h12, d1);
		bus_seen = 1'b0;
		mv(8'h07);
		`CHK(bus_seen, 1'b0)
		wr(8'h14, 8'h00);
		wr(8'h12, d2);
		mv(8'h07);
		`CHK(i_mem.hit_q, 16'h0300)
		rd(8'h13, 8'h02, 8'h02);
		wr(8'h14, 8'h00);
		mv(8'h05);
		rd(8'h12, d1);
		wr(8'h14, 8'h00);
		mv(8'h05);
		rd(8'h12, d2);
		wr(8'h11, 8'ha0);
		bus_seen = 1'b0;
		mv(8'h03);
		`CHK(bus_seen, 1'b0)
		wr(8'h14, 8'h00);
		wr(8'h8e, 8'h02);
		wr(8'ha0, 8'h3c);
		wr(8'h11, 8'h55);
		wr(8'h12, d1);
		mv(8'h03);
		`CHK(i_mem.hit_q, 16'h3c55)
		mv(8'h07);
		`CHK(i_mem.hit_q, 16'h02ff)
		slow <= 1'b1;
		wr(8'h11, 8'h55);
		mv(8'h01);
		rd(8'h12, d1);
		slow <= 1'b0;
		cnt(10);
		wr(8'h8f, 8'h01);
		cnt(20);
		wr(8'h8f, 8'h00);
		wr(8'h8e, 8'h03);
		@(posedge core_clk_in);
		cnt(0);
		n0 = n_ale;
		mv(8'h08);
		`CHK(n_ale - n0, 1)
		repeat (40) begin
			nt[9:0] = $random(seed);
			acc <= '{valid: 1'b1, addr: nt[7:0], indirect: nt[8], stack: nt[9]};
			aq.push_back({(nt[7:0] <= 8'h7f) ? DMS_REG_LOWER :
				((nt[8] || nt[9]) ? DMS_REG_UPPER : DMS_REG_SPECIAL), nt[7:0]});
			@(posedge core_clk_in);
		end
		acc <= '0;
		repeat (3) @(posedge core_clk_in);
		test_done();
	end
endmodule
`default_nettype wire
